// file: hw/exp_bus_pkg.sv
// constants and carrier types for the expansion bus controller
package exp_bus_pkg;
	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 24;
	localparam int NUM_CS     = 8;
	localparam int CS_W       = 3;
	localparam int PH_W       = 4;
	localparam int MIN_SIZE_LOG = 9;
	localparam int MAX_SIZE_LOG = 24;
	localparam int HPI_FIRST_CS = 4;
	localparam logic [CS_W-1:0] HPI_FIRST = 3'h4;
	localparam logic [PH_W-1:0] PH_ONE    = 4'h1;
	localparam logic [7:0]      STRAP_RST = 8'h00;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_SET  = 3'b010,
		PH_STRB = 3'b011,
		PH_HOLD = 3'b100,
		PH_REC  = 3'b101
	} phase_t;

	// per-select configuration
	typedef struct packed {
		logic            enable;
		logic [ADDR_W-1:0] base;
		logic [4:0]      sizeLog;   // log2 of window bytes
		logic            strobeStyle; // 0 split rd/wr, 1 rw with data strobe
		logic            muxed;
		logic            hostPort;
		logic            hostByte;  // 1 byte mode, 0 halfword mode
		logic [PH_W-1:0] tAddr;
		logic [PH_W-1:0] tSet;
		logic [PH_W-1:0] tStrb;
		logic [PH_W-1:0] tHold;
		logic [PH_W-1:0] tRec;
	} cs_cfg_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;

	// pin group toward the peripherals
	typedef struct packed {
		logic [NUM_CS-1:0] csN;
		logic [ADDR_W-1:0] addr;
		logic              aleOut;
		logic              rdN;
		logic              wrN;
		logic              rwN;
		logic              dsN;
		logic [DATA_W-1:0] dOut;
		logic              dOeN;
	} pins_t;
endpackage

// file: hw/cs_decode.sv
// address window decode for all chip selects
`timescale 1ns/1ps
module cs_decode #(
	parameter int N = exp_bus_pkg::NUM_CS
) (
	input  wire logic [exp_bus_pkg::ADDR_W-1:0] addr,
	input  exp_bus_pkg::cs_cfg_t                cfg [N],
	output logic [N-1:0]                        hit
);
	import exp_bus_pkg::*;

	// window match: compare bits above the window size
	function automatic logic inWindow(input logic [ADDR_W-1:0] a, input cs_cfg_t c);
		logic [ADDR_W-1:0] mask;
		logic [4:0]        sz;
		sz = (c.sizeLog < 5'(MIN_SIZE_LOG)) ? 5'(MIN_SIZE_LOG) : c.sizeLog;
		mask = (sz >= 5'(MAX_SIZE_LOG)) ? '0 : ~((ADDR_W'(1) << sz) - ADDR_W'(1));
		inWindow = c.enable && ((a & mask) == (c.base & mask));
	endfunction

	// lowest numbered select wins on overlap
	always_comb begin
		logic found;
		found = 1'b0;
		hit = '0;
		for (int i = 0; i < N; i++) begin
			if (!found && inWindow(addr, cfg[i])) begin
				hit[i] = 1'b1;
				found = 1'b1;
			end
		end
	end
endmodule // cs_decode

// file: hw/exp_bus_ctrl.sv
// expansion bus controller: phase sequencer and pin drive
`timescale 1ns/1ps
module exp_bus_ctrl #(
	parameter int NCS = exp_bus_pkg::NUM_CS
) (
	input  wire logic                           sys_clk,
	input  wire logic                           sys_rst,
	input  wire logic                           clkEn,
	input  exp_bus_pkg::cs_cfg_t                csCfg [NCS],
	input  exp_bus_pkg::req_t                   req,
	output logic                                reqReady,
	output logic                                done,
	output logic [exp_bus_pkg::DATA_W-1:0]      rdata,
	output logic                                missErr,
	input  wire logic [exp_bus_pkg::ADDR_W-1:0] addrIn,
	input  wire logic [exp_bus_pkg::DATA_W-1:0] dataIn,
	output exp_bus_pkg::pins_t                  pins,
	output logic                                clkPinOe,
	output logic [exp_bus_pkg::ADDR_W-1:0]      strapOut
);
	import exp_bus_pkg::*;

	typedef struct packed {
		phase_t            ph;
		logic [PH_W-1:0]   cnt;
		logic [CS_W-1:0]   sel;
		logic              write;
		logic              hiByte;   // second byte of host-port byte mode
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              ready;
		logic              done;
		logic              miss;
		logic              inRst;
		logic              clkPinOe; // low keeps the clock pin driven
		logic [ADDR_W-1:0] strap;
		pins_t             pins;
	} state_t;

	state_t stateReg, stateNext;
	logic [NCS-1:0] hit;
	logic [CS_W-1:0] hitIdx;
	cs_cfg_t cur;

	////////////////////////////////////////////////////////////////
	// decode
	cs_decode #(.N(NCS)) uDec (
		.addr (req.addr),
		.cfg  (csCfg),
		.hit  (hit)
	);

	// encode one-hot hit
	always_comb begin
		hitIdx = '0;
		for (int i = 0; i < NCS; i++) begin
			if (hit[i]) hitIdx = CS_W'(i);
		end
	end

	assign cur = csCfg[stateReg.sel];

	// length of a phase, zero treated as one cycle
	function automatic logic [PH_W-1:0] phLen(input phase_t p, input cs_cfg_t c);
		logic [PH_W-1:0] v;
		unique case (p)
			PH_ADDR: v = c.tAddr;
			PH_SET:  v = c.tSet;
			PH_STRB: v = c.tStrb;
			PH_HOLD: v = c.tHold;
			default: v = c.tRec;
		endcase
		phLen = (v == '0) ? PH_ONE : v;
	endfunction

	function automatic logic hostMode(input logic [CS_W-1:0] s, input cs_cfg_t c);
		hostMode = c.hostPort && (s >= HPI_FIRST);
	endfunction

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		stateNext = stateReg;
		stateNext.done = 1'b0;
		stateNext.miss = 1'b0;
		stateNext.inRst = 1'b0;
		stateNext.clkPinOe = 1'b0;
		// straps latch on the first enabled cycle after release
		if (stateReg.inRst) begin
			stateNext.strap = addrIn;
		end
		unique case (stateReg.ph)
			PH_IDLE: begin
				if (req.valid && stateReg.ready) begin
					if (hit == '0) begin
						stateNext.miss = 1'b1;
						stateNext.done = 1'b1;
					end else begin
						stateNext.ph = PH_ADDR;
						stateNext.sel = hitIdx;
						stateNext.write = req.write;
						stateNext.addr = req.addr;
						stateNext.wdata = req.wdata;
						stateNext.hiByte = 1'b0;
						stateNext.cnt = phLen(PH_ADDR, csCfg[hitIdx]);
						stateNext.ready = 1'b0;
					end
				end
			end
			default: begin
				if (stateReg.cnt > PH_ONE) begin
					stateNext.cnt = stateReg.cnt - PH_ONE;
				end else begin
					unique case (stateReg.ph)
						PH_ADDR: stateNext.ph = PH_SET;
						PH_SET:  stateNext.ph = PH_STRB;
						PH_STRB: stateNext.ph = PH_HOLD;
						PH_HOLD: stateNext.ph = PH_REC;
						default: stateNext.ph = PH_IDLE;
					endcase
					if (stateReg.ph == PH_STRB && !stateReg.write) begin
						if (hostMode(stateReg.sel, cur) && cur.hostByte) begin
							if (stateReg.hiByte) stateNext.rdata[15:8] = dataIn[7:0];
							else stateNext.rdata[7:0] = dataIn[7:0];
						end else begin
							stateNext.rdata = dataIn;
						end
					end
					// byte mode runs a second pass for the upper byte
					if (stateReg.ph == PH_REC) begin
						if (hostMode(stateReg.sel, cur) && cur.hostByte && !stateReg.hiByte) begin
							stateNext.ph = PH_ADDR;
							stateNext.hiByte = 1'b1;
						end else begin
							stateNext.done = 1'b1;
							stateNext.ready = 1'b1;
						end
					end
					stateNext.cnt = phLen(stateNext.ph, cur);
				end
			end
		endcase

		// pin drive from the phase just chosen
		stateNext.pins.csN = '1;
		stateNext.pins.aleOut = 1'b0;
		stateNext.pins.rdN = 1'b1;
		stateNext.pins.wrN = 1'b1;
		stateNext.pins.rwN = 1'b1;
		stateNext.pins.dsN = 1'b1;
		stateNext.pins.dOeN = 1'b1;
		stateNext.pins.addr = stateNext.addr;
		stateNext.pins.dOut = stateNext.wdata;
		if (stateNext.ph != PH_IDLE && stateNext.ph != PH_REC) begin
			stateNext.pins.csN[stateNext.sel] = 1'b0;
			stateNext.pins.rwN = !stateNext.write;
			if (stateNext.hiByte) stateNext.pins.dOut = {8'h00, stateNext.wdata[15:8]};
			else if (hostMode(stateNext.sel, csCfg[stateNext.sel])
				&& csCfg[stateNext.sel].hostByte) stateNext.pins.dOut = {8'h00, stateNext.wdata[7:0]};
			if (stateNext.ph == PH_ADDR && csCfg[stateNext.sel].muxed) begin
				stateNext.pins.aleOut = 1'b1;
				stateNext.pins.dOut = stateNext.addr[DATA_W-1:0];
				stateNext.pins.dOeN = 1'b0;
			end else if (stateNext.write) begin
				stateNext.pins.dOeN = 1'b0;
			end
			if (stateNext.ph == PH_STRB) begin
				if (csCfg[stateNext.sel].strobeStyle) stateNext.pins.dsN = 1'b0;
				else if (stateNext.write) stateNext.pins.wrN = 1'b0;
				else stateNext.pins.rdN = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stateReg <= '0;
			stateReg.ph <= PH_IDLE;
			stateReg.ready <= 1'b1;
			stateReg.inRst <= 1'b1;
			stateReg.pins.csN <= '1;
			stateReg.pins.rdN <= 1'b1;
			stateReg.pins.wrN <= 1'b1;
			stateReg.pins.rwN <= 1'b1;
			stateReg.pins.dsN <= 1'b1;
			stateReg.pins.dOeN <= 1'b1;
		end else if (clkEn) begin
			stateReg <= stateNext;
		end
	end

	assign reqReady = stateReg.ready;
	assign done = stateReg.done;
	assign rdata = stateReg.rdata;
	assign missErr = stateReg.miss;
	assign pins = stateReg.pins;
	assign strapOut = stateReg.strap;
	assign clkPinOe = stateReg.clkPinOe;

	////////////////////////////////////////////////////////////////
	// checks
	chk_one_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$countones(~pins.csN) <= 1) else $error("more than one select active");
	chk_strobe_phase: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!pins.rdN || !pins.wrN || !pins.dsN) |-> stateReg.ph == PH_STRB)
		else $error("strobe outside strobe phase");
	chk_phase_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clkEn && stateReg.ph == PH_SET && stateNext.ph != PH_SET) |=> stateReg.ph == PH_STRB)
		else $error("setup not followed by strobe");
	chk_miss_no_cs: assert property (@(posedge sys_clk) disable iff (sys_rst)
		missErr |-> pins.csN == '1) else $error("select active on miss");
	chk_host_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateReg.hiByte |-> stateReg.sel >= HPI_FIRST) else $error("host mode on low select");
	chk_mux_ale: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pins.aleOut |-> (stateReg.ph == PH_ADDR && pins.dOeN == 1'b0))
		else $error("latch strobe outside address phase");
	chk_style_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pins.dsN |-> (pins.rdN && pins.wrN)) else $error("both strobe styles active");
	chk_clk_pin: assert property (@(posedge sys_clk) clkPinOe == 1'b0)
		else $error("clock pin not driven");
	chk_strap_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!stateReg.inRst && clkEn) |=> $stable(strapOut)) else $error("straps changed");
endmodule // exp_bus_ctrl

// file: verif/periph_model.sv
// peripheral model: answers reads, keeps the last written halfword
`timescale 1ns/1ps
module periph_model (
	input  wire logic          sys_clk,
	input  exp_bus_pkg::pins_t pins,
	output logic [15:0]        dataIn,
	output logic [15:0]        lastWr
);
	import exp_bus_pkg::*;
	logic [15:0] prevOut = 16'h0000;
	logic        rdAct;
	logic        wrAct;
	// either strobe style counts as a strobe
	assign rdAct = ~&pins.csN && (!pins.rdN || (!pins.dsN && pins.rwN));
	assign wrAct = ~&pins.csN && (!pins.wrN || (!pins.dsN && !pins.rwN));
	// a released bus toggles, so a late sample cannot match by luck
	assign dataIn = rdAct ? {pins.addr[7:0], ~pins.addr[15:8]} : ~prevOut;
	always_ff @(posedge sys_clk) begin
		prevOut <= dataIn;
		if (wrAct) lastWr <= pins.dOut;
	end
endmodule // periph_model

// file: verif/async_expansion_bus_controller_tb.sv
// self-checking bench for the expansion bus controller
`timescale 1ns/1ps
module async_expansion_bus_controller_tb;
	import exp_bus_pkg::*;
	typedef struct {
		logic        miss;
		logic        chk;
		logic        wr;
		logic [15:0] data;
		int          lat;
		int          ale;
		int          ds;
		int          rw;
	} note_t;
	logic        sys_clk   = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        clkEn     = 1'b1;
	req_t        req       = '0;
	logic [23:0] addrIn    = 24'h000000;
	logic [7:0]  expCsN    = 8'hFF;
	logic [31:0] lfsrState = 32'hAF2A;
	cs_cfg_t     cfg [NUM_CS];
	logic        reqReady, done, missErr, clkPinOe;
	logic [15:0] rdata, dataIn, lastWr;
	logic [23:0] strapOut, strap;
	pins_t       pins;
	note_t       note;
	note_t       q [$];
	int          fail_count = 0, samples_checked = 0, cyc = 0, takeCyc = 0;
	int          aleCnt = 0, dsCnt = 0, rwCnt = 0;

	// bench clock at 4 ns, faster than the real bus limit
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	exp_bus_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .csCfg(cfg),
		.req(req), .reqReady(reqReady), .done(done), .rdata(rdata), .missErr(missErr),
		.addrIn(addrIn), .dataIn(dataIn), .pins(pins), .clkPinOe(clkPinOe),
		.strapOut(strapOut));
	periph_model peer (.sys_clk(sys_clk), .pins(pins), .dataIn(dataIn), .lastWr(lastWr));

	////////////////////////////////////////
	function automatic logic [31:0] lfsr();
		lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h8020_0003)};
		return lfsrState;
	endfunction

	// zero phase lengths still take one cycle; byte host mode runs twice
	function automatic int phaseSum(cs_cfg_t c);
		int s;
		s = (c.tAddr ? c.tAddr : 1) + (c.tSet ? c.tSet : 1) + (c.tStrb ? c.tStrb : 1);
		s = s + (c.tHold ? c.tHold : 1) + (c.tRec ? c.tRec : 1);
		return (c.hostPort && c.hostByte) ? 2 * s : s;
	endfunction

	task automatic cmpVal(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic cmpBit(input logic got, input logic want);
		cmpVal({31'h0, got}, {31'h0, want});
	endtask

	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// one access; cs below zero means no window should match
	task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d,
		input int cs, input int stall);
		note_t e;
		int    n;
		int    k;
		int    passes;
		logic  byteMode;
		k = (cs < 0) ? 0 : cs;
		byteMode = (cs >= 0) && cfg[k].hostPort && cfg[k].hostByte;
		passes = (cs < 0) ? 0 : (byteMode ? 2 : 1);
		e.miss = (cs < 0);
		e.chk = (cs >= 0);
		e.wr = w;
		// byte host mode: low byte first, high byte last, each on bits 7:0
		if (byteMode) e.data = w ? {8'h00, d[15:8]} : {~a[15:8], ~a[15:8]};
		else e.data = w ? d : {a[7:0], ~a[15:8]};
		// counted from the falling edge before the taking edge
		e.lat = ((cs < 0) ? 0 : phaseSum(cfg[k])) + 1 + stall;
		e.ale = cfg[k].muxed ? passes * (cfg[k].tAddr ? cfg[k].tAddr : 1) : 0;
		e.ds = cfg[k].strobeStyle ? passes * (cfg[k].tStrb ? cfg[k].tStrb : 1) : 0;
		e.rw = cfg[k].strobeStyle ? 0 : passes * (cfg[k].tStrb ? cfg[k].tStrb : 1);
		expCsN = (cs < 0) ? 8'hFF : ~(8'h01 << cs);
		// note goes in before the taking edge, so a miss cannot race the scoreboard
		takeCyc = cyc;
		q.push_back(e);
		req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(negedge sys_clk);
		req.valid <= 1'b0;
		// a frozen clock enable must stretch the access by the same count
		if (stall > 0) begin
			clkEn <= 1'b0;
			repeat (stall) @(negedge sys_clk);
			clkEn <= 1'b1;
		end
		for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge sys_clk);
		if (n == 300) begin
			fail_count++;
			finish_test();
		end
		@(negedge sys_clk);
	endtask

	////////////////////////////////////////
	// scoreboard: select lines on every cycle with a select low, oldest note on each done
	always @(negedge sys_clk) begin
		if (pins.csN !== 8'hFF) cmpVal({24'h0, pins.csN}, {24'h0, expCsN});
		// cycles of latch strobe and of each strobe style within one access
		if (pins.aleOut === 1'b1) aleCnt++;
		if (pins.dsN === 1'b0) dsCnt++;
		if (pins.rdN === 1'b0 || pins.wrN === 1'b0) rwCnt++;
		if (done === 1'b1) begin
			cmpBit(q.size() != 0, 1'b1);
			cmpBit(reqReady, 1'b1);
			if (q.size() != 0) begin
				note = q.pop_front();
				cmpBit(missErr, note.miss);
				cmpVal(32'(cyc - takeCyc), 32'(note.lat));
				if (note.chk) cmpVal({16'h0, note.wr ? lastWr : rdata}, {16'h0, note.data});
				cmpVal(32'(aleCnt), 32'(note.ale));
				cmpVal(32'(dsCnt), 32'(note.ds));
				cmpVal(32'(rwCnt), 32'(note.rw));
			end
			aleCnt = 0;
			dsCnt = 0;
			rwCnt = 0;
		end
	end

	// main sequence
	initial begin
		int i;
		strap = 24'(lfsr());
		addrIn = strap;
		for (i = 0; i < NUM_CS; i++) begin
			cfg[i] = '0;
			cfg[i].enable = 1'b1;
			cfg[i].base = 24'(i) << 20;
			cfg[i].sizeLog = (i == 0) ? 5'h09 : 5'h0C;
			cfg[i].strobeStyle = i[0];
			cfg[i].muxed = i[1];
			cfg[i].hostPort = (i >= HPI_FIRST_CS);
			cfg[i].hostByte = i[0];
			cfg[i].tAddr = 4'(lfsr() & 3);
			cfg[i].tSet = 4'(lfsr() & 3);
			cfg[i].tStrb = 4'(lfsr() & 3);
			cfg[i].tHold = 4'(lfsr() & 3);
			cfg[i].tRec = 4'(lfsr() & 3);
		end
		repeat (6) @(negedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(negedge sys_clk);
		addrIn <= ~strap;
		cmpBit(clkPinOe, 1'b0);
		@(negedge sys_clk);
		cmpVal({8'h0, strapOut}, {8'h0, strap});
		for (i = 0; i < NUM_CS; i++) begin
			access(1'b1, cfg[i].base + 24'h000002, 16'(lfsr()), i, 0);
			access(1'b0, cfg[i].base + 24'h000004, 16'h0000, i, 0);
		end
		access(1'b0, 24'h0001FE, 16'h0000, 0, 0);
		access(1'b0, 24'h000200, 16'h0000, -1, 0);
		access(1'b1, 24'h701000, 16'h1234, -1, 0);
		access(1'b0, 24'h100010, 16'h0000, 1, 3);
		finish_test();
	end
endmodule // async_expansion_bus_controller_tb
